// *** rtl/slc_link_map.vh ***
`ifndef SLC_LINK_MAP_VH
`define SLC_LINK_MAP_VH
`define SLC_ADDR_QUICK_CFG 8'h5e
`define SLC_ADDR_LINK_CTRL 8'h5f
`define SLC_ADDR_CHK_LANE0 8'h78
`define SLC_ADDR_CHK_LANE1 8'h79
`define SLC_CTRL_RESET_BIT 0
`define SLC_CTRL_RESET_VAL 8'h01
`define SLC_QCFG_RESET_VAL 8'h11
`define SLC_QCFG_1C1L 8'h11
`define SLC_QCFG_1C2L 8'h12
`define SLC_QCFG_2C1L 8'h21
`define SLC_QCFG_2C2L 8'h22
`define SLC_CHK_PARAM_COUNT 11
`define SLC_LANE_COUNT 2
`define SLC_LANE0_ID 5'h00
`define SLC_LANE1_ID 5'h01
`define SLC_LM1_ONE 5'h00
`define SLC_LM1_TWO 5'h01
`define SLC_FM1_ONE 8'h00
`define SLC_FM1_TWO 8'h01
`define SLC_FM1_FOUR 8'h03
`define SLC_MM1_ONE 8'h00
`define SLC_MM1_TWO 8'h01
`define SLC_SM1_ONE 5'h00
`define SLC_HD_OFF 1'b0
`define SLC_HD_ON 1'b1
`define SLC_KM1_FIXED 8'h1f
`define SLC_NM1_FIXED 8'h0d
`define SLC_NPM1_FIXED 8'h0f
`define SLC_CONV_RESET_VAL 2'h1
`define SLC_LANE_RESET_VAL 2'h1
`define SLC_FPF_RESET_VAL 8'h02
`define SLC_CHK_RESET_VAL 8'h00
`define SLC_RDATA_RESET_VAL 8'h00
`define SLC_RDATA_UNMAPPED 8'h00
`endif

// *** rtl/slc_link_setup.v ***
// Operation
// - Writing one to control bit 0 disables the link and holds it in reset.
// - Quick configuration write selects the link configuration and derived parameters.
// - Code 0x11 one converter one lane; 0x12 one converter two lanes.
// - Code 0x21 two converters one lane; 0x22 two converters two lanes.
// - Writing zero to control bit 0 releases the link and starts synchronization.
// - Checksum is the modulo 256 sum of the unpacked parameter fields.
// - Lane 0 checksum readable at one register, lane 1 at the next.
`timescale 1ns/10ps
`include "slc_link_map.vh"
module slc_link_setup (
  input wire ref_clk,
  input wire rst_n,
  input wire regWrEn,
  input wire regRdEn,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  output reg [7:0] regRdData,
  output wire linkReset,
  output wire syncStart,
  output reg [1:0] convCount,
  output reg [1:0] laneCount,
  output reg [7:0] octetsPerFrame,
  output reg [7:0] lane0Checksum,
  output reg [7:0] lane1Checksum
);
  localparam [1:0] LINK_HELD = 2'b00;
  localparam [1:0] LINK_START = 2'b01;
  localparam [1:0] LINK_RUN = 2'b10;

  reg [7:0] quickCfg_r;
  reg [7:0] quickCfg_nxt;
  reg [7:0] linkCtrl_r;
  reg [7:0] linkCtrl_nxt;
  reg [1:0] linkState_r;
  reg [1:0] linkState_nxt;
  reg [7:0] regRdData_nxt;
  reg [1:0] convCount_nxt;
  reg [1:0] laneCount_nxt;
  reg [7:0] octetsPerFrame_nxt;
  reg [4:0] lanesM1;
  reg [7:0] octetsM1;
  reg [7:0] convM1;
  reg [4:0] samplesM1;
  reg highDens;
  wire wrQuick;
  wire wrCtrl;
  wire holdNxt;
  wire [15:0] chkBus;
  wire [7:0] chk0;
  wire [7:0] chk1;
  genvar lane;

  assign wrQuick = regWrEn & (regAddr == `SLC_ADDR_QUICK_CFG);
  assign wrCtrl = regWrEn & (regAddr == `SLC_ADDR_LINK_CTRL);

  // Writes to unmapped addresses leave every register untouched
  always @* begin
    quickCfg_nxt = quickCfg_r;
    linkCtrl_nxt = linkCtrl_r;
    if (wrQuick) begin
      quickCfg_nxt = regWrData;
    end
    if (wrCtrl) begin
      linkCtrl_nxt = regWrData;
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      quickCfg_r <= `SLC_QCFG_RESET_VAL;
      linkCtrl_r <= `SLC_CTRL_RESET_VAL;
    end else begin
      quickCfg_r <= quickCfg_nxt;
      linkCtrl_r <= linkCtrl_nxt;
    end
  end

  assign linkReset = linkCtrl_r[`SLC_CTRL_RESET_BIT];
  assign holdNxt = linkCtrl_nxt[`SLC_CTRL_RESET_BIT];

  // The sequencer follows the next control value so the start pulse lines up
  // with the first cycle in which the link is out of reset
  always @* begin
    linkState_nxt = linkState_r;
    case (linkState_r)
      LINK_HELD: begin
        if (!holdNxt) begin
          linkState_nxt = LINK_START;
        end
      end
      LINK_START: begin
        if (holdNxt) begin
          linkState_nxt = LINK_HELD;
        end else begin
          linkState_nxt = LINK_RUN;
        end
      end
      LINK_RUN: begin
        if (holdNxt) begin
          linkState_nxt = LINK_HELD;
        end
      end
      default: begin
        linkState_nxt = LINK_HELD;
      end
    endcase
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      linkState_r <= LINK_HELD;
    end else begin
      linkState_r <= linkState_nxt;
    end
  end

  // One pulse per release; writing zero again to a running link starts nothing
  assign syncStart = (linkState_r == LINK_START);

  // Unknown codes fall back to the one-converter one-lane layout but still read back as written
  always @* begin
    case (quickCfg_r)
      `SLC_QCFG_1C1L: begin
        lanesM1 = `SLC_LM1_ONE;
        octetsM1 = `SLC_FM1_TWO;
        convM1 = `SLC_MM1_ONE;
        samplesM1 = `SLC_SM1_ONE;
        highDens = `SLC_HD_OFF;
      end
      `SLC_QCFG_1C2L: begin
        lanesM1 = `SLC_LM1_TWO;
        octetsM1 = `SLC_FM1_ONE;
        convM1 = `SLC_MM1_ONE;
        samplesM1 = `SLC_SM1_ONE;
        highDens = `SLC_HD_ON;
      end
      `SLC_QCFG_2C1L: begin
        lanesM1 = `SLC_LM1_ONE;
        octetsM1 = `SLC_FM1_FOUR;
        convM1 = `SLC_MM1_TWO;
        samplesM1 = `SLC_SM1_ONE;
        highDens = `SLC_HD_OFF;
      end
      `SLC_QCFG_2C2L: begin
        lanesM1 = `SLC_LM1_TWO;
        octetsM1 = `SLC_FM1_TWO;
        convM1 = `SLC_MM1_TWO;
        samplesM1 = `SLC_SM1_ONE;
        highDens = `SLC_HD_OFF;
      end
      default: begin
        lanesM1 = `SLC_LM1_ONE;
        octetsM1 = `SLC_FM1_TWO;
        convM1 = `SLC_MM1_ONE;
        samplesM1 = `SLC_SM1_ONE;
        highDens = `SLC_HD_OFF;
      end
    endcase
  end

  // The link carries counts as value minus one; the host sees plain counts
  always @* begin
    convCount_nxt = convM1[1:0] + 2'h1;
    laneCount_nxt = lanesM1[1:0] + 2'h1;
    octetsPerFrame_nxt = octetsM1 + 8'h01;
  end

  // One checksum adder per lane; lanes differ only in their lane number
  generate
    for (lane = 0; lane < `SLC_LANE_COUNT; lane = lane + 1) begin : gLane
      slc_param_checksum uChk (
        .laneId((lane == 0) ? `SLC_LANE0_ID : `SLC_LANE1_ID),
        .lanesMinus1(lanesM1),
        .octetsMinus1(octetsM1),
        .convMinus1(convM1),
        .samplesMinus1(samplesM1),
        .highDensity(highDens),
        .paramChecksum(chkBus[lane * 8 +: 8])
      );
    end
  endgenerate

  assign chk0 = chkBus[7:0];
  assign chk1 = chkBus[15:8];

  // Read data holds between reads; unmapped addresses read as zero
  always @* begin
    regRdData_nxt = regRdData;
    if (regRdEn) begin
      case (regAddr)
        `SLC_ADDR_QUICK_CFG: begin
          regRdData_nxt = quickCfg_r;
        end
        `SLC_ADDR_LINK_CTRL: begin
          regRdData_nxt = linkCtrl_r;
        end
        `SLC_ADDR_CHK_LANE0: begin
          regRdData_nxt = chk0;
        end
        `SLC_ADDR_CHK_LANE1: begin
          regRdData_nxt = chk1;
        end
        default: begin
          regRdData_nxt = `SLC_RDATA_UNMAPPED;
        end
      endcase
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      convCount <= `SLC_CONV_RESET_VAL;
      laneCount <= `SLC_LANE_RESET_VAL;
      octetsPerFrame <= `SLC_FPF_RESET_VAL;
      lane0Checksum <= `SLC_CHK_RESET_VAL;
      lane1Checksum <= `SLC_CHK_RESET_VAL;
      regRdData <= `SLC_RDATA_RESET_VAL;
    end else begin
      convCount <= convCount_nxt;
      laneCount <= laneCount_nxt;
      octetsPerFrame <= octetsPerFrame_nxt;
      lane0Checksum <= chk0;
      lane1Checksum <= chk1;
      regRdData <= regRdData_nxt;
    end
  end
endmodule // slc_link_setup

// *** rtl/slc_param_checksum.v ***
`timescale 1ns/10ps
`include "slc_link_map.vh"
module slc_param_checksum (
  input wire [4:0] laneId,
  input wire [4:0] lanesMinus1,
  input wire [7:0] octetsMinus1,
  input wire [7:0] convMinus1,
  input wire [4:0] samplesMinus1,
  input wire highDensity,
  output wire [7:0] paramChecksum
);
  // K-1, N-1 and N'-1 are fixed by the converter; the lane number is added, other identity and option fields add zero
  wire [7:0] sum;
  assign sum = {3'h0, laneId} + {3'h0, lanesMinus1} + octetsMinus1 + `SLC_KM1_FIXED + convMinus1
    + `SLC_NM1_FIXED + `SLC_NPM1_FIXED + {3'h0, samplesMinus1} + {7'h00, highDensity};
  assign paramChecksum = sum;
endmodule // slc_param_checksum

// *** test/serial_link_setup_control_tb.sv ***
`timescale 1ns/10ps
module serial_link_setup_control_tb;
  reg ref_clk = 0, rst_n = 0, regWrEn = 0, regRdEn = 0;
  reg [7:0] regAddr = 8'h00, regWrData = 8'h00, q;
  wire [7:0] regRdData, octetsPerFrame, lane0Checksum, lane1Checksum, syncCount;
  wire linkReset, syncStart;
  wire [1:0] convCount, laneCount;
  integer fails = 0, check_count = 0, i;
  always #4 ref_clk = ~ref_clk;
  slc_link_setup uut(.ref_clk(ref_clk), .rst_n(rst_n), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .linkReset(linkReset), .syncStart(syncStart),
    .convCount(convCount), .laneCount(laneCount), .octetsPerFrame(octetsPerFrame),
    .lane0Checksum(lane0Checksum), .lane1Checksum(lane1Checksum));
  slc_rx_model rx(.ref_clk(ref_clk), .linkReset(linkReset), .syncStart(syncStart), .syncCount(syncCount));
  // Fixed fields K-1, N-1 and N'-1 add 0x3b; the rest follow the code
  function [7:0] chk(input [7:0] c, input [7:0] lid);
    chk = 8'h3b + c[1] + c[5] + (c == 8'h12 ? 8'h01 : 8'h00) + fpf(c) - 8'h01 + lid;
  endfunction
  function [7:0] fpf(input [7:0] c);
    fpf = c == 8'h12 ? 8'h01 : (c == 8'h21 ? 8'h04 : 8'h02);
  endfunction
  task cmp(input [7:0] got, input [7:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task acc(input w, input [7:0] a, input [7:0] d);
    @(posedge ref_clk);
    #1 regWrEn = w;
    regRdEn = !w;
    regAddr = a;
    regWrData = d;
    @(posedge ref_clk);
    #1 regWrEn = 0;
    regRdEn = 0;
  endtask
  task close_out;
    $display("fails %0d check_count %0d", fails, check_count);
    if (fails == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    i = $urandom(92361);
    repeat (6) @(posedge ref_clk);
    #1 rst_n = 1;
    for (i = 0; i < 8; i = i + 1) begin
      q = i < 4 ? i : $urandom % 4;
      q = 8'h11 + (q[1] ? 8'h10 : 8'h00) + q[0];
      acc(1, 8'h5f, 8'h01);
      acc(1, 8'h5e, q);
      acc(0, 8'h5e, 8'h00);
      cmp(regRdData, q);
      cmp({7'h0, linkReset}, 8'h01);
      cmp({4'h0, convCount, laneCount}, {4'h0, q[5] ? 2'h2 : 2'h1, q[1] ? 2'h2 : 2'h1});
      cmp(octetsPerFrame, fpf(q));
      cmp(lane0Checksum, chk(q, 8'h00));
      cmp(lane1Checksum, chk(q, 8'h01));
      acc(0, 8'h78, 8'h00);
      cmp(regRdData, chk(q, 8'h00));
      acc(0, 8'h79, 8'h00);
      cmp(regRdData, chk(q, 8'h01));
      acc(1, 8'h80, $urandom);
      acc(0, 8'h80, 8'h00);
      cmp(regRdData, 8'h00);
      acc(1, 8'h5f, 8'h00);
      @(posedge ref_clk);
      #1 cmp(syncCount, i + 1);
      cmp({7'h0, linkReset}, 8'h00);
    end
    // Mid-run reset must bring the link back to held with the default layout and no false start
    @(posedge ref_clk);
    #1 rst_n = 0;
    repeat (2) @(posedge ref_clk);
    #1 rst_n = 1;
    cmp({7'h0, linkReset}, 8'h01);
    acc(0, 8'h5f, 8'h00);
    cmp(regRdData, 8'h01);
    acc(0, 8'h5e, 8'h00);
    cmp(regRdData, 8'h11);
    cmp(syncCount, 8'h08);
    // An undefined code reads back as written but runs the one-converter one-lane layout
    acc(1, 8'h5e, 8'h33);
    acc(0, 8'h5e, 8'h00);
    cmp(regRdData, 8'h33);
    cmp({4'h0, convCount, laneCount}, 8'h05);
    cmp(octetsPerFrame, fpf(8'h11));
    cmp(lane1Checksum, chk(8'h11, 8'h01));
    acc(0, 8'h78, 8'h00);
    cmp(regRdData, chk(8'h11, 8'h00));
    acc(1, 8'h5f, 8'h00);
    @(posedge ref_clk);
    #1 cmp(syncCount, 8'h09);
    close_out;
  end
  initial begin
    #20000 fails = fails + 1;
    close_out;
  end
endmodule // serial_link_setup_control_tb
bind slc_link_setup slc_setup_chk chk(.ref_clk(ref_clk), .rst_n(rst_n), .regWrEn(regWrEn), .regAddr(regAddr),
  .regWrData(regWrData), .linkReset(linkReset), .syncStart(syncStart), .convCount(convCount),
  .laneCount(laneCount), .octetsPerFrame(octetsPerFrame));

// *** test/slc_rx_model.sv ***
`timescale 1ns/10ps
module slc_rx_model (
  input wire ref_clk,
  input wire linkReset,
  input wire syncStart,
  output reg [7:0] syncCount
);
  initial syncCount = 8'h00;
  // Only a release seen while the link is out of reset starts alignment
  always @(posedge ref_clk) begin
    if (syncStart && !linkReset) begin
      syncCount <= syncCount + 8'h01;
    end
  end
endmodule // slc_rx_model

// *** test/slc_setup_chk.sv ***
`timescale 1ns/10ps
module slc_setup_chk (
  input wire ref_clk,
  input wire rst_n,
  input wire regWrEn,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire linkReset,
  input wire syncStart,
  input wire [1:0] convCount,
  input wire [1:0] laneCount,
  input wire [7:0] octetsPerFrame
);
  wire wq = regWrEn && regAddr == 8'h5e;
  wire wc = regWrEn && regAddr == 8'h5f;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  hold_reset_a: assert property (wc && regWrData[0] |=> linkReset) else $error("no hold");
  release_sync_a: assert property (wc && !regWrData[0] && linkReset |=> syncStart) else $error("no sync");
  sync_pulse_a: assert property (syncStart |=> !syncStart) else $error("long sync");
  sync_cause_a: assert property (syncStart |-> !linkReset && $past(linkReset)) else $error("bad sync");
  one_lane_a: assert property (wq && regWrData == 8'h11 |-> ##2 convCount == 2'h1 && laneCount == 2'h1
    && octetsPerFrame == 8'h02) else $error("cfg 11");
  two_lane_a: assert property (wq && regWrData == 8'h12 |-> ##2 laneCount == 2'h2 && octetsPerFrame == 8'h01)
    else $error("cfg 12");
  two_conv_a: assert property (wq && regWrData == 8'h21 |-> ##2 convCount == 2'h2 && laneCount == 2'h1
    && octetsPerFrame == 8'h04) else $error("cfg 21");
  both_two_a: assert property (wq && regWrData == 8'h22 |-> ##2 convCount == 2'h2 && laneCount == 2'h2)
    else $error("cfg 22");
endmodule // slc_setup_chk
